//--- common/dsnr_pkg.sv
// Constants for the sag, surge and idle status register bank
`default_nettype none
package dsnr_pkg;
   // Data widths
   localparam int DW = 32;
   localparam int AW = 16;
   localparam int VW = 24;
   localparam int NCH = 7;
   localparam int NPH = 3;
   localparam int IDW = 18;
   localparam int SELW = 3;
   localparam int STW = 7;
   // Register indices; byte address is four times the index
   localparam logic [11:0] IDX_DIP_THR   = 12'h410;
   localparam logic [11:0] IDX_DIP_A     = 12'h411;
   localparam logic [11:0] IDX_DIP_B     = 12'h412;
   localparam logic [11:0] IDX_DIP_C     = 12'h413;
   localparam logic [11:0] IDX_SWL_THR   = 12'h414;
   localparam logic [11:0] IDX_SWL_A     = 12'h415;
   localparam logic [11:0] IDX_SWL_B     = 12'h416;
   localparam logic [11:0] IDX_SWL_C     = 12'h417;
   localparam logic [11:0] IDX_IDLE      = 12'h41f;
   localparam logic [11:0] IDX_SRC_SEL   = 12'h424;
   localparam logic [11:0] IDX_EVT_EN    = 12'h430;
   localparam logic [11:0] IDX_IRQ_STAT  = 12'h431;
   localparam logic [11:0] IDX_IRQ_EN    = 12'h432;
   localparam logic [11:0] IDX_IRQ_CLR   = 12'h433;
   // Reset values
   localparam logic [VW-1:0] RST_DIP_THR = 24'h000000;
   localparam logic [VW-1:0] RST_DIP_VAL = 24'h7fffff;
   localparam logic [VW-1:0] RST_SWL_THR = 24'hffffff;
   localparam logic [VW-1:0] RST_SWL_VAL = 24'h000000;
   localparam logic [SELW-1:0] RST_SEL   = 3'h7;
   localparam logic [SELW-1:0] SEL_OWN   = 3'h7;
   // Source select field positions: lowest bit of the IA and VC fields, top bit of the whole select
   localparam int SEL_IA_LSB = 0;
   localparam int SEL_VC_LSB = 18;
   localparam int SEL_TOP    = 20;
   // Channel numbering matches the select codes
   localparam int CH_IA = 0;
   localparam int CH_IB = 1;
   localparam int CH_IC = 2;
   localparam int CH_IN = 3;
   localparam int CH_VA = 4;
   localparam int CH_VB = 5;
   localparam int CH_VC = 6;
   // Event enable layout: sag bits 0..2, surge bits 3..5
   localparam int EVT_SAG_LSB = 0;
   localparam int EVT_SRG_LSB = 3;
   localparam int EVT_W       = 6;
   // Interrupt status layout
   localparam int ST_SAG_LSB  = 0;
   localparam int ST_SRG_LSB  = 3;
   localparam int ST_IDLE_BIT = 6;
endpackage
`default_nettype wire

//--- hdl/dsnr_regs.sv
// APB register bank for sag, surge, idle status and channel redirect
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// [RL1] Writable 24-bit sag threshold, reset zero, compared with each half-cycle rms.
// [RL2] Per-phase read-only sag rms captured during sag; resets to 7fffff.
// [RL3] Writable 24-bit surge threshold, reset all ones, compared per phase.
// [RL4] Per-phase read-only surge rms captured during surge; resets to zero.
// [RL5] Idle status bits, six per phase, phase A bits 0-5, B 6-11, C 12-17.
// [RL6] Idle bits clear at reset, bits 31:18 reserved, set only while idle.
// [RL7] Field 20:18 picks phase C voltage channel source, reset 7.
// [RL8] Codes 000..101 route IA, IB, IC, IN, VA, VB data.
// [RL9] Same 3-bit fields for other six channels, reset 7, 111 own data.
// [RL10] Active-low event output low on enabled sag or surge condition.
// [RL11] Reserved bits read zero; writes to read-only parts ignored.
module dsnr_regs (
   input  wire logic              clk,
   input  wire logic              nrst,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [15:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Half-cycle rms per phase with update strobe
   input  wire logic [23:0]       rms_a,
   input  wire logic [23:0]       rms_b,
   input  wire logic [23:0]       rms_c,
   input  wire logic [2:0]        rms_upd,
   // Idle detector flags, same layout as the status word
   input  wire logic [17:0]       idle_flags,
   // Raw converter data
   input  wire logic [23:0]       adc_ia,
   input  wire logic [23:0]       adc_ib,
   input  wire logic [23:0]       adc_ic,
   input  wire logic [23:0]       adc_in,
   input  wire logic [23:0]       adc_va,
   input  wire logic [23:0]       adc_vb,
   input  wire logic [23:0]       adc_vc,
   // Redirected processing channel data
   output logic      [23:0]       chan_ia,
   output logic      [23:0]       chan_ib,
   output logic      [23:0]       chan_ic,
   output logic      [23:0]       chan_in,
   output logic      [23:0]       chan_va,
   output logic      [23:0]       chan_vb,
   output logic      [23:0]       chan_vc,
   // Event pin and interrupt
   output logic                   event_n,
   output logic                   irq
);

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   // Select one source for a channel; code 111 keeps its own data
   function automatic logic [23:0] route(
      input logic [2:0]   code,
      input int           own,
      input logic [23:0]  src [7]
   );
      logic [23:0] res;
      res = src[own];
      if (code != dsnr_pkg::SEL_OWN) begin
         res = src[code];
      end
      return res;
   endfunction

   // Match a byte address against a register index
   function automatic logic hit(
      input logic [15:0] addr,
      input logic [11:0] idx
   );
      return addr == {2'h0, idx, 2'h0};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // State

   logic [23:0]  dip_thr_r, dip_thr_nxt;
   logic [23:0]  swl_thr_r, swl_thr_nxt;
   logic [23:0]  dip_val_r [3];
   logic [23:0]  dip_val_nxt [3];
   logic [23:0]  swl_val_r [3];
   logic [23:0]  swl_val_nxt [3];
   logic [2:0]   in_dip_r, in_dip_nxt;
   logic [2:0]   in_swl_r, in_swl_nxt;
   logic [17:0]  idle_r, idle_nxt;
   logic [20:0]  sel_r, sel_nxt;
   logic [5:0]   evt_en_r, evt_en_nxt;
   logic [6:0]   stat_r, stat_nxt;
   logic [6:0]   irq_en_r, irq_en_nxt;
   logic [31:0]  prdata_r, prdata_nxt;
   logic         pready_r, pready_nxt;
   logic         pslverr_r, pslverr_nxt;
   logic         event_n_r, event_n_nxt;
   logic         irq_r, irq_nxt;
   logic [23:0]  chan_r [7];
   logic [23:0]  chan_nxt [7];

   logic [23:0]  rms [3];
   logic [23:0]  adc [7];
   logic         wr_en;
   logic         mapped;

   assign rms = '{rms_a, rms_b, rms_c};
   assign adc = '{adc_ia, adc_ib, adc_ic, adc_in, adc_va, adc_vb, adc_vc};
   // Write lands on the access edge only
   assign wr_en = psel & penable & pready_r & pwrite;

   ////////////////////////////////////////////////////////////////////////
   // APB read path and answer

   // Decode during setup; answer in the first access cycle
   always_comb begin
      mapped = 1'b1;
      prdata_nxt = 32'h00000000;
      // [RL11] reserved reads zero
      unique case (1'b1)
         hit(paddr, dsnr_pkg::IDX_DIP_THR):
            prdata_nxt[23:0] = dip_thr_r;
         hit(paddr, dsnr_pkg::IDX_DIP_A):
            prdata_nxt[23:0] = dip_val_r[0];
         hit(paddr, dsnr_pkg::IDX_DIP_B):
            prdata_nxt[23:0] = dip_val_r[1];
         hit(paddr, dsnr_pkg::IDX_DIP_C):
            prdata_nxt[23:0] = dip_val_r[2];
         hit(paddr, dsnr_pkg::IDX_SWL_THR):
            prdata_nxt[23:0] = swl_thr_r;
         hit(paddr, dsnr_pkg::IDX_SWL_A):
            prdata_nxt[23:0] = swl_val_r[0];
         hit(paddr, dsnr_pkg::IDX_SWL_B):
            prdata_nxt[23:0] = swl_val_r[1];
         hit(paddr, dsnr_pkg::IDX_SWL_C):
            prdata_nxt[23:0] = swl_val_r[2];
         // [RL6] reserved idle bits zero
         hit(paddr, dsnr_pkg::IDX_IDLE):
            prdata_nxt[17:0] = idle_r;
         hit(paddr, dsnr_pkg::IDX_SRC_SEL):
            prdata_nxt[20:0] = sel_r;
         hit(paddr, dsnr_pkg::IDX_EVT_EN):
            prdata_nxt[5:0] = evt_en_r;
         hit(paddr, dsnr_pkg::IDX_IRQ_STAT):
            prdata_nxt[6:0] = stat_r;
         hit(paddr, dsnr_pkg::IDX_IRQ_EN):
            prdata_nxt[6:0] = irq_en_r;
         hit(paddr, dsnr_pkg::IDX_IRQ_CLR):
            prdata_nxt = 32'h00000000;   // Write-only
         default:
            mapped = 1'b0;
      endcase
      pready_nxt = psel & ~penable;
      pslverr_nxt = psel & ~penable & ~mapped;
      if (!(psel & ~penable)) begin
         prdata_nxt = prdata_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Software-writable settings

   // Thresholds, redirect fields and event enables
   always_comb begin
      dip_thr_nxt = dip_thr_r;
      swl_thr_nxt = swl_thr_r;
      sel_nxt = sel_r;
      evt_en_nxt = evt_en_r;
      irq_en_nxt = irq_en_r;
      if (wr_en) begin
         // [RL1] sag threshold write
         if (hit(paddr, dsnr_pkg::IDX_DIP_THR)) begin
            dip_thr_nxt = pwdata[23:0];
         end
         // [RL3] surge threshold write
         if (hit(paddr, dsnr_pkg::IDX_SWL_THR)) begin
            swl_thr_nxt = pwdata[23:0];
         end
         // [RL7] [RL9] select fields write
         if (hit(paddr, dsnr_pkg::IDX_SRC_SEL)) begin
            sel_nxt = pwdata[20:0];
         end
         if (hit(paddr, dsnr_pkg::IDX_EVT_EN)) begin
            evt_en_nxt = pwdata[5:0];
         end
         if (hit(paddr, dsnr_pkg::IDX_IRQ_EN)) begin
            irq_en_nxt = pwdata[6:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sag and surge tracking

   // Compare each phase on its half-cycle update
   always_comb begin
      in_dip_nxt = in_dip_r;
      in_swl_nxt = in_swl_r;
      dip_val_nxt = dip_val_r;
      swl_val_nxt = swl_val_r;
      for (int p = 0; p < 3; p++) begin
         if (rms_upd[p]) begin
            // [RL1] sag compare
            in_dip_nxt[p] = rms[p] < dip_thr_r;
            // [RL3] surge compare
            in_swl_nxt[p] = rms[p] > swl_thr_r;
            // [RL2] capture sag rms
            if (rms[p] < dip_thr_r) begin
               dip_val_nxt[p] = rms[p];
            end
            // [RL4] capture surge rms
            if (rms[p] > swl_thr_r) begin
               swl_val_nxt[p] = rms[p];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Idle status, event pin, interrupt

   // Status follows detector; sticky events with set over clear
   always_comb begin
      logic [6:0] set;
      logic [6:0] clr;
      set = 7'h00;
      clr = 7'h00;
      // [RL5] [RL6] idle bits track detector
      idle_nxt = idle_flags;
      set[2:0] = in_dip_nxt & ~in_dip_r;
      set[5:3] = in_swl_nxt & ~in_swl_r;
      set[6] = |(idle_flags & ~idle_r);
      if (wr_en && hit(paddr, dsnr_pkg::IDX_IRQ_CLR)) begin
         clr = pwdata[6:0];
      end
      stat_nxt = (stat_r & ~clr) | set;
      irq_nxt = |(stat_nxt & irq_en_r);
      // [RL10] event pin low when enabled
      event_n_nxt = ~(|({in_swl_nxt, in_dip_nxt} & evt_en_r));
   end

   ////////////////////////////////////////////////////////////////////////
   // Channel redirect

   // Route each channel through its select field
   always_comb begin
      for (int c = 0; c < 7; c++) begin
         // [RL8] [RL9] source decode
         chan_nxt[c] = route(sel_r[3*c +: 3], c, adc);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers

   // APB answer flops
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         prdata_r  <= 32'h00000000;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         prdata_r  <= prdata_nxt;
         pready_r  <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   // Software settings flops
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dip_thr_r <= dsnr_pkg::RST_DIP_THR;
         swl_thr_r <= dsnr_pkg::RST_SWL_THR;
         sel_r     <= {7{dsnr_pkg::RST_SEL}};
         evt_en_r  <= 6'h00;
         irq_en_r  <= 7'h00;
      end else begin
         dip_thr_r <= dip_thr_nxt;
         swl_thr_r <= swl_thr_nxt;
         sel_r     <= sel_nxt;
         evt_en_r  <= evt_en_nxt;
         irq_en_r  <= irq_en_nxt;
      end
   end

   // Sag and surge state, captured values
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int p = 0; p < 3; p++) begin
            dip_val_r[p] <= dsnr_pkg::RST_DIP_VAL;
            swl_val_r[p] <= dsnr_pkg::RST_SWL_VAL;
         end
         in_dip_r  <= 3'h0;
         in_swl_r  <= 3'h0;
      end else begin
         dip_val_r <= dip_val_nxt;
         swl_val_r <= swl_val_nxt;
         in_dip_r  <= in_dip_nxt;
         in_swl_r  <= in_swl_nxt;
      end
   end

   // Idle mirror, sticky status, event pin, interrupt
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         idle_r    <= 18'h00000;
         stat_r    <= 7'h00;
         event_n_r <= 1'b1;
         irq_r     <= 1'b0;
      end else begin
         idle_r    <= idle_nxt;
         stat_r    <= stat_nxt;
         event_n_r <= event_n_nxt;
         irq_r     <= irq_nxt;
      end
   end

   // Redirected channel data
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int c = 0; c < 7; c++) begin
            chan_r[c] <= 24'h000000;
         end
      end else begin
         chan_r    <= chan_nxt;
      end
   end

   // Outputs straight from flops
   assign prdata  = prdata_r;
   assign pready  = pready_r;
   assign pslverr = pslverr_r;
   assign event_n = event_n_r;
   assign irq     = irq_r;
   assign chan_ia = chan_r[dsnr_pkg::CH_IA];
   assign chan_ib = chan_r[dsnr_pkg::CH_IB];
   assign chan_ic = chan_r[dsnr_pkg::CH_IC];
   assign chan_in = chan_r[dsnr_pkg::CH_IN];
   assign chan_va = chan_r[dsnr_pkg::CH_VA];
   assign chan_vb = chan_r[dsnr_pkg::CH_VB];
   assign chan_vc = chan_r[dsnr_pkg::CH_VC];

endmodule // dsnr_regs
`default_nettype wire

//--- verification/dip_swell_noload_regs_tb.sv
// Self-checking bench for the sag, surge and idle register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin \
   samples_checked++; \
   if ((a) !== (e)) begin \
      err_total++; \
      $display("MISMATCH t=%0t got %h exp %h", $time, (a), (e)); \
   end \
end
module dip_swell_noload_regs_tb;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [15:0] paddr = 16'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic        pready, pslverr, er, event_n, irq;
   logic [23:0] rms [3];
   logic [23:0] adc [7];
   logic [23:0] chan [7];
   logic [2:0]  rms_upd = 3'h0;
   logic [17:0] idle_flags = 18'h0;
   logic [23:0] t, s;
   logic [2:0]  c;
   int          f;
   int          err_total = 0;
   int          samples_checked = 0;
   logic [11:0] ri [10] = '{dsnr_pkg::IDX_DIP_THR, dsnr_pkg::IDX_DIP_A,
      dsnr_pkg::IDX_DIP_B, dsnr_pkg::IDX_DIP_C, dsnr_pkg::IDX_SWL_THR,
      dsnr_pkg::IDX_SWL_A, dsnr_pkg::IDX_SWL_B, dsnr_pkg::IDX_SWL_C,
      dsnr_pkg::IDX_IDLE, dsnr_pkg::IDX_SRC_SEL};
   logic [31:0] rv [10] = '{32'h0, 32'h7fffff, 32'h7fffff, 32'h7fffff,
      32'hffffff, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1fffff};

   // Clock
   always #5 clk = ~clk;

   dsnr_regs i_dsnr_regs (
      .clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rms_a(rms[0]), .rms_b(rms[1]),
      .rms_c(rms[2]), .rms_upd(rms_upd), .idle_flags(idle_flags),
      .adc_ia(adc[0]), .adc_ib(adc[1]), .adc_ic(adc[2]), .adc_in(adc[3]),
      .adc_va(adc[4]), .adc_vb(adc[5]), .adc_vc(adc[6]),
      .chan_ia(chan[0]), .chan_ib(chan[1]), .chan_ic(chan[2]),
      .chan_in(chan[3]), .chan_va(chan[4]), .chan_vb(chan[5]),
      .chan_vc(chan[6]), .event_n(event_n), .irq(irq)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Verdict and end of run
   task automatic close_out();
      $display("checked %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // One APB transfer, bounded wait for pready
   task automatic apb(input logic w, input logic [11:0] i,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'h0, i, 2'h0};
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // No answer within the bound ends the run
      if (pready !== 1'b1) begin
         err_total++;
         close_out();
      end
   endtask

   // One rms update strobe on phase p
   task automatic upd(input int p, input logic [23:0] v);
      @(posedge clk);
      rms[p] <= v;
      rms_upd <= 3'h1 << p;
      @(posedge clk);
      rms_upd <= 3'h0;
      @(posedge clk);
   endtask

   // Expected channel data for a select code
   function automatic logic [23:0] route(int ch, logic [2:0] code);
      return (code == 3'h7) ? adc[ch] : adc[code];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(98));
      foreach (adc[k]) adc[k] = 24'($urandom);
      foreach (rms[k]) rms[k] = 24'h0;
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      // Reset values of the threshold, value, idle and select registers
      foreach (ri[k]) begin
         apb(1'b0, ri[k], 32'h0);
         `CHK(rd, rv[k])
      end
      // Read-only write ignored, unmapped refused
      apb(1'b1, dsnr_pkg::IDX_DIP_A, 32'h0);
      apb(1'b0, dsnr_pkg::IDX_DIP_A, 32'h0);
      `CHK(rd, 32'h7fffff)
      apb(1'b0, 12'h400, 32'h0);
      `CHK({er, rd}, {1'b1, 32'h0})
      // Sag on phase A, strict boundary first
      t = 24'($urandom_range(24'h7ffff0, 24'h10));
      apb(1'b1, dsnr_pkg::IDX_EVT_EN, 32'h3f);
      apb(1'b1, dsnr_pkg::IDX_DIP_THR, {8'hff, t});
      apb(1'b0, dsnr_pkg::IDX_DIP_THR, 32'h0);
      `CHK(rd, {8'h0, t})
      upd(0, t);
      apb(1'b0, dsnr_pkg::IDX_DIP_A, 32'h0);
      `CHK(rd, 32'h7fffff)
      upd(0, t - 24'h1);
      apb(1'b0, dsnr_pkg::IDX_DIP_A, 32'h0);
      `CHK(rd, {8'h0, t - 24'h1})
      `CHK(event_n, 1'b0)
      // Interrupt raised, masked, enabled, cleared
      apb(1'b0, dsnr_pkg::IDX_IRQ_STAT, 32'h0);
      `CHK({irq, rd}, {1'b0, 32'h1})
      apb(1'b1, dsnr_pkg::IDX_IRQ_EN, 32'h1);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b1)
      apb(1'b1, dsnr_pkg::IDX_IRQ_CLR, 32'h1);
      apb(1'b0, dsnr_pkg::IDX_IRQ_STAT, 32'h0);
      `CHK({irq, rd}, {1'b0, 32'h0})
      upd(0, t);
      `CHK(event_n, 1'b1)
      // Surge on phase B
      s = 24'($urandom_range(24'hfffff0, 24'h10));
      apb(1'b1, dsnr_pkg::IDX_SWL_THR, {8'hff, s});
      apb(1'b0, dsnr_pkg::IDX_SWL_THR, 32'h0);
      `CHK(rd, {8'h0, s})
      upd(1, s + 24'h1);
      apb(1'b0, dsnr_pkg::IDX_SWL_B, 32'h0);
      `CHK({event_n, rd}, {1'b0, 8'h0, s + 24'h1})
      // Surge B entry, plus sag B entry when below the sag level
      apb(1'b0, dsnr_pkg::IDX_IRQ_STAT, 32'h0);
      `CHK(rd, 32'h10 | ((s + 24'h1 < t) ? 32'h2 : 32'h0))
      // Idle status mirror, all ones first
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         idle_flags <= (k == 0) ? 18'h3ffff : 18'($urandom);
         apb(1'b0, dsnr_pkg::IDX_IDLE, 32'h0);
         `CHK(rd, {14'h0, idle_flags})
      end
      // Rising idle flag left its sticky status bit
      apb(1'b0, dsnr_pkg::IDX_IRQ_STAT, 32'h0);
      `CHK(rd[6], 1'b1)
      // Every code on channel C, then random fields
      for (int k = 0; k < 14; k++) begin
         f = (k < 8) ? 6 : $urandom_range(5, 0);
         c = (k < 8) ? 3'(k) : 3'($urandom);
         @(posedge clk);
         foreach (adc[j]) adc[j] <= 24'($urandom);
         apb(1'b1, dsnr_pkg::IDX_SRC_SEL,
             (32'h1fffff & ~(32'h7 << 3 * f)) | (32'(c) << 3 * f));
         repeat (3) @(posedge clk);
         `CHK(chan[f], route(f, c))
      end
      // Mid-run reset restores the threshold, value, idle and select registers
      idle_flags <= 18'h0;
      @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      `CHK({event_n, irq}, 2'h2)
      foreach (ri[k]) begin
         apb(1'b0, ri[k], 32'h0);
         `CHK(rd, rv[k])
      end
      close_out();
   end
endmodule // dip_swell_noload_regs_tb
`default_nettype wire

//--- verification/dsnr_regs_properties.sv
// Concurrent checks for the sag, surge and idle register bank
`timescale 1ns/1ps
`default_nettype none
module dsnr_regs_properties (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [2:0]  rms_upd,
   input wire logic [23:0] adc_ia,
   input wire logic [23:0] adc_vc,
   input wire logic [23:0] chan_vc,
   input wire logic        event_n
);
   logic        wr_acc;
   logic [23:0] thr_r;
   logic [23:0] thr_nxt;
   logic [2:0]  vc_r;
   logic [2:0]  vc_nxt;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   ////////////////////////////////////////////////////////////////////////////
   // Shadow of sag threshold and channel C select
   assign wr_acc = psel && penable && pready && pwrite;
   always_comb begin
      thr_nxt = thr_r;
      vc_nxt = vc_r;
      if (wr_acc && paddr == 16'h1040) thr_nxt = pwdata[23:0];
      if (wr_acc && paddr == 16'h1090) vc_nxt = pwdata[20:18];
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         thr_r <= 24'h000000;
         vc_r <= 3'h7;
      end else begin
         thr_r <= thr_nxt;
         vc_r <= vc_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   a_ready_once:
      assert property (pready |=> !pready) else $error("pready too long");
   a_ready_setup:
      assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   a_err_unmapped:
      assert property (pready |-> pslverr == !(paddr[15:2] inside
         {[14'h410:14'h417], 14'h41f, 14'h424, [14'h430:14'h433]}))
      else $error("pslverr wrong for address");
   a_thr_readback:
      assert property (pready && !pwrite && paddr == 16'h1040
         |-> prdata == {8'h00, thr_r}) else $error("sag threshold read");
   a_value_resv:
      assert property (pready && !pwrite && paddr[15:2] inside
         {[14'h411:14'h417]} |-> prdata[31:24] == 8'h00)
      else $error("value upper bits set");
   a_idle_resv:
      assert property (pready && !pwrite && paddr == 16'h107c
         |-> prdata[31:18] == 14'h0000) else $error("idle upper bits set");
   a_sel_read:
      assert property (pready && !pwrite && paddr == 16'h1090
         |-> prdata[31:21] == 11'h000 && prdata[20:18] == vc_r)
      else $error("select read wrong");
   a_chan_own:
      assert property ($past(nrst) && $past(vc_r) == 3'h7
         |-> chan_vc == $past(adc_vc)) else $error("own data not routed");
   a_chan_code0:
      assert property ($past(nrst) && $past(vc_r) == 3'h0
         |-> chan_vc == $past(adc_ia)) else $error("code 0 not routed");
   // Enable write lands one edge before the pin flop sees it
   a_event_cause:
      assert property ($fell(event_n) |-> $past(|rms_upd)
         || $past(wr_acc, 2))
      else $error("event without cause");
endmodule // dsnr_regs_properties

bind dsnr_regs dsnr_regs_properties i_dsnr_regs_properties (
   .clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .rms_upd(rms_upd),
   .adc_ia(adc_ia), .adc_vc(adc_vc), .chan_vc(chan_vc), .event_n(event_n)
);
`default_nettype wire
